// [ipll_pkg.sv]
// shared types and constants for the integer-N divider control block
package ipll_pkg;

  localparam int unsigned PROG_W = 20;
  localparam int unsigned AUX_W  = 8;
  localparam int unsigned PIN_W  = 43;

  // dual-modulus prescaler ratios and high time of its raw output
  localparam logic [3:0] PRE_DIV_LO   = 4'hA;
  localparam logic [3:0] PRE_DIV_HI   = 4'hB;
  localparam logic [3:0] PRE_HIGH_CNT = 4'h5;

  // auxiliary_control bits kept in bus order: bit n of the register sits at index 7-n
  localparam int unsigned AUX_PWDN  = 4;
  localparam int unsigned AUX_CLOAD = 3;
  localparam int unsigned AUX_MODULUS_SELECT_LINE  = 2;
  localparam int unsigned AUX_PRE   = 1;
  localparam int unsigned AUX_OEDIS = 0;

  // mclk cycles of quiet pumps before lock_indicator is released
  localparam logic [7:0] LOCK_FILT_CYC = 8'h10;

  localparam logic [PROG_W-1:0] PROG_RST = 20'h00000;
  localparam logic [AUX_W-1:0]  AUX_RST  = 8'h00;

  typedef enum logic [1:0] {
    IPLL_MODE_PAR   = 2'b00,
    IPLL_MODE_SER   = 2'b01,
    IPLL_MODE_STRAP = 2'b11
  } ipll_mode_e;

  // counter_program_word, first serial bit at the top
  typedef struct packed {
    logic [1:0] ref_hi;
    logic [1:0] main_hi;
    logic       pre_en_n;
    logic [6:0] main_lo;
    logic [3:0] ref_lo;
    logic [3:0] swallow;
  } ipll_prog_s;

  // every programming and clock pin of the device
  typedef struct packed {
    logic       rf_in;
    logic       ref_in;
    logic [7:0] par_bus;
    logic       main_low_byte_strobe;
    logic       main_high_bits_strobe;
    logic       swallow_ref_strobe;
    logic       freq_switch_strobe;
    logic       aux_reg_strobe;
    logic       par_bank_select;
    logic       serial_in;
    logic       serial_shift_clock;
    logic       serial_load_strobe;
    logic       ser_bank_select;
    logic       bus_mode_select;
    logic       serial_select;
    logic       aux_ctrl_enable_n;
    ipll_prog_s strap_word;
  } ipll_pins_s;

endpackage

// [ipll_pin_sync.sv]
// three-stage pin synchroniser with agreement filter and edge pulses
`timescale 1ns/10ps
`default_nettype none
module ipll_pin_sync #(
  parameter int unsigned WIDTH = 8
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] lvl,
  output logic      [WIDTH-1:0] rise,
  output logic      [WIDTH-1:0] fall
);

  genvar gi;
  generate
    for (gi = 0; gi < WIDTH; gi++) begin : g_bit
      logic s1_r;
      logic s2_r;
      logic s3_r;
      logic lvl_r;
      logic rise_r;
      logic fall_r;

      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          s1_r <= 1'b0;
          s2_r <= 1'b0;
          s3_r <= 1'b0;
        end else begin
          s1_r <= din[gi];
          s2_r <= s1_r;
          s3_r <= s2_r;
        end
      end

      // a change counts only once stages two and three agree
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          lvl_r  <= 1'b0;
          rise_r <= 1'b0;
          fall_r <= 1'b0;
        end else begin
          rise_r <= (s2_r == s3_r) && s3_r && !lvl_r;
          fall_r <= (s2_r == s3_r) && !s3_r && lvl_r;
          if (s2_r == s3_r) begin
            lvl_r <= s3_r;
          end
        end
      end

      assign lvl[gi]  = lvl_r;
      assign rise[gi] = rise_r;
      assign fall[gi] = fall_r;
    end
  endgenerate

endmodule
`default_nettype wire

// [ipll_divider_ctrl.sv]
// integer-N synthesizer digital core: programming, dividers, phase detector, lock
// Function
// - pre_en_n low uses the 10/11 prescaler; high bypasses it and stops it.
// - main ratio with prescaler is 10*(M+1)+A, M 9 bits, A at most M+1.
// - M of one gives a main counter ratio of two.
// - bypassed prescaler: main chain divides by M+1 and ignores swallow value.
// - strap mode forces main bits 8:7 and ref bits 5:4 to zero.
// - ref counter divides reference by R+1; R zero passes reference straight through.
// - mode select: bus low/serial low parallel, bus low/serial high serial, bus high strap.
// - parallel strobes load three sections of the program word from the byte bus.
// - parallel: freq_switch_strobe rising copies primary into secondary.
// - parallel: par_bank_select high uses primary, low uses secondary.
// - parallel: aux strobe rising captures bus; bits act only with enable low.
// - serial: twenty bits shift into primary on shift clock, first bit highest.
// - serial: load strobe or freq_switch rising copies primary into secondary.
// - serial: ser_bank_select high uses primary, low uses secondary.
// - serial with aux strobe high: eight bits shift into aux shift stage.
// - serial aux bits reach the holding buffer only on aux strobe falling.
// - aux bits 0-2 reserved; bit n is bus bit 7-n; bit 3 powers down.
// - aux bit 4 loads counters immediately and continuously from selected source.
// - bit 5 shows modulus select, bit 6 prescaler output, bit 7 disables the two divided outputs.
// - every aux control bit is active high.
// - phase detector: main edge first pulses down pump, ref first pulses up pump.
// - filter node is NAND of pumps; open-drain lock indicator is their filtered AND.
// - prescaler divides by ten or eleven as modulus select chooses.
// - counter values live in one 20-bit program word.
`timescale 1ns/10ps
`default_nettype none
module ipll_divider_ctrl (
  input  wire logic                mclk,
  input  wire logic                sys_rst,
  input  wire ipll_pkg::ipll_pins_s pins,
  output logic                     main_divided_clk,
  output logic                     ref_divided_clk,
  output logic                     pump_up_n,
  output logic                     pump_down_n,
  output logic                     lock_filter_node,
  output logic                     lock_indicator_o,
  output logic                     lock_indicator_oe,
  output logic                     diag_out
);
  import ipll_pkg::*;

  logic [PIN_W-1:0] lvl_v;
  logic [PIN_W-1:0] rise_v;
  logic [PIN_W-1:0] fall_v;
  ipll_pins_s       lvl;
  ipll_pins_s       rise;
  ipll_pins_s       fall;

  ipll_mode_e       mode;
  ipll_prog_s       pri_r;
  ipll_prog_s       sec_r;
  ipll_prog_s       src;
  ipll_prog_s       act_r;
  logic [AUX_W-1:0] aux_sh_r;
  logic [AUX_W-1:0] aux_buf_r;
  logic [AUX_W-1:0] aux_eff;

  logic             pwdn;
  logic             cload;
  logic             bypass;
  logic [8:0]       m_val;
  logic [5:0]       r_val;
  logic [3:0]       pre_cnt_r;
  logic [8:0]       m_cnt_r;
  logic [5:0]       r_cnt_r;
  logic             modulus_select_line;
  logic             pre_evt;
  logic             pre_out;
  logic             main_wrap;
  logic             ref_wrap;
  logic             up_n_nxt;
  logic             dn_n_nxt;
  logic [7:0]       lock_cnt_r;

  logic             main_div_r;
  logic             ref_div_r;
  logic             pump_up_n_r;
  logic             pump_down_n_r;
  logic             filt_node_r;
  logic             lock_oe_r;
  logic             diag_r;

  // every pin, clocks included, is sampled by mclk; edges come as one-cycle pulses
  ipll_pin_sync #(
    .WIDTH (PIN_W)
  ) u_sync (
    .clk  (mclk),
    .rst  (sys_rst),
    .din  (pins),
    .lvl  (lvl_v),
    .rise (rise_v),
    .fall (fall_v)
  );

  assign lvl  = lvl_v;
  assign rise = rise_v;
  assign fall = fall_v;

  always_comb begin
    if (lvl.bus_mode_select) begin
      mode = IPLL_MODE_STRAP;
    end else if (lvl.serial_select) begin
      mode = IPLL_MODE_SER;
    end else begin
      mode = IPLL_MODE_PAR;
    end
  end

  // primary program word
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      pri_r <= PROG_RST;
    end else begin
      case (mode)
        IPLL_MODE_PAR: begin
          if (rise.main_high_bits_strobe) begin
            {pri_r.ref_hi, pri_r.main_hi} <= lvl.par_bus[3:0];
          end
          if (rise.main_low_byte_strobe) begin
            {pri_r.pre_en_n, pri_r.main_lo} <= lvl.par_bus;
          end
          if (rise.swallow_ref_strobe) begin
            {pri_r.ref_lo, pri_r.swallow} <= lvl.par_bus;
          end
        end
        IPLL_MODE_SER: begin
          // first bit ends up at the top after twenty shifts
          if (rise.serial_shift_clock && !lvl.serial_load_strobe && !lvl.aux_reg_strobe) begin
            pri_r <= ipll_prog_s'({pri_r[PROG_W-2:0], lvl.serial_in});
          end
        end
        default: begin
          pri_r <= pri_r;
        end
      endcase
    end
  end

  // secondary program word; a copy in the same cycle as a shift takes the old word
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      sec_r <= PROG_RST;
    end else begin
      case (mode)
        IPLL_MODE_PAR: begin
          if (rise.freq_switch_strobe) begin
            sec_r <= pri_r;
          end
        end
        IPLL_MODE_SER: begin
          if (rise.serial_load_strobe || rise.freq_switch_strobe) begin
            sec_r <= pri_r;
          end
        end
        default: begin
          sec_r <= sec_r;
        end
      endcase
    end
  end

  // auxiliary shift stage, kept apart so outputs never glitch while shifting
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      aux_sh_r <= AUX_RST;
    end else if (mode == IPLL_MODE_SER && rise.serial_shift_clock &&
                 lvl.aux_reg_strobe && !lvl.serial_load_strobe) begin
      aux_sh_r <= {aux_sh_r[AUX_W-2:0], lvl.serial_in};
    end
  end

  // auxiliary_control holding buffer, stored in bus order
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      aux_buf_r <= AUX_RST;
    end else begin
      case (mode)
        IPLL_MODE_PAR: begin
          if (rise.aux_reg_strobe) begin
            aux_buf_r <= lvl.par_bus;
          end
        end
        IPLL_MODE_SER: begin
          if (fall.aux_reg_strobe) begin
            aux_buf_r <= aux_sh_r;
          end
        end
        default: begin
          aux_buf_r <= aux_buf_r;
        end
      endcase
    end
  end

  // reserved bits are carried but steer nothing
  assign aux_eff = lvl.aux_ctrl_enable_n ? AUX_RST : aux_buf_r;
  assign pwdn    = aux_eff[AUX_PWDN] == 1'b1;
  assign cload   = aux_eff[AUX_CLOAD] == 1'b1;

  // counter source selection
  always_comb begin
    case (mode)
      IPLL_MODE_PAR: begin
        src = lvl.par_bank_select ? pri_r : sec_r;
      end
      IPLL_MODE_SER: begin
        src = lvl.ser_bank_select ? pri_r : sec_r;
      end
      IPLL_MODE_STRAP: begin
        src         = lvl.strap_word;
        src.ref_hi  = 2'h0;
        src.main_hi = 2'h0;
      end
      default: begin
        src = sec_r;
      end
    endcase
  end

  // counters pick up new values at the end of a main cycle or during power down, so a change never
  // truncates a main period, unless immediate loading is asked for
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      act_r <= PROG_RST;
    end else if (cload || main_wrap || pwdn) begin
      act_r <= src;
    end
  end

  assign bypass = act_r.pre_en_n;
  assign m_val  = {act_r.main_hi, act_r.main_lo};
  assign r_val  = {act_r.ref_hi, act_r.ref_lo};

  // swallow: divide by eleven for the first A prescaler periods of a main cycle
  assign modulus_select_line = !bypass && (m_cnt_r < {5'h00, act_r.swallow});

  always_comb begin
    if (bypass) begin
      pre_evt = rise.rf_in && !pwdn;
    end else begin
      pre_evt = rise.rf_in && !pwdn &&
                (pre_cnt_r == (modulus_select_line ? PRE_DIV_HI - 4'h1 : PRE_DIV_LO - 4'h1));
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      pre_cnt_r <= 4'h0;
    end else if (pwdn || bypass) begin
      pre_cnt_r <= 4'h0;
    end else if (rise.rf_in) begin
      pre_cnt_r <= pre_evt ? 4'h0 : pre_cnt_r + 4'h1;
    end
  end

  // M+1 prescaler outputs per main cycle; M of one gives two
  assign main_wrap = pre_evt && (m_cnt_r >= m_val);

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      m_cnt_r <= 9'h000;
    end else if (pwdn) begin
      m_cnt_r <= 9'h000;
    end else if (pre_evt) begin
      m_cnt_r <= main_wrap ? 9'h000 : m_cnt_r + 9'h001;
    end
  end

  assign ref_wrap = rise.ref_in && !pwdn && (r_cnt_r >= r_val);

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      r_cnt_r <= 6'h00;
    end else if (pwdn) begin
      r_cnt_r <= 6'h00;
    end else if (rise.ref_in) begin
      r_cnt_r <= ref_wrap ? 6'h00 : r_cnt_r + 6'h01;
    end
  end

  assign pre_out = bypass ? lvl.rf_in : (pre_cnt_r < PRE_HIGH_CNT);

  // divided outputs: high for the first period of each count; with R zero the ref output follows the reference
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      main_div_r <= 1'b0;
      ref_div_r  <= 1'b0;
    end else if (pwdn || aux_eff[AUX_OEDIS]) begin
      main_div_r <= 1'b0;
      ref_div_r  <= 1'b0;
    end else begin
      main_div_r <= (m_cnt_r == 9'h000);
      ref_div_r  <= (r_val == 6'h00) ? lvl.ref_in : (r_cnt_r == 6'h00);
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      diag_r <= 1'b0;
    end else if (aux_eff[AUX_MODULUS_SELECT_LINE]) begin
      diag_r <= modulus_select_line;
    end else if (aux_eff[AUX_PRE]) begin
      diag_r <= pre_out && !pwdn;
    end else begin
      diag_r <= 1'b0;
    end
  end

  // phase-frequency detector; once both pumps fire they reset together
  always_comb begin
    up_n_nxt = pump_up_n_r && !ref_wrap;
    dn_n_nxt = pump_down_n_r && !main_wrap;
    if (pwdn || (!up_n_nxt && !dn_n_nxt)) begin
      up_n_nxt = 1'b1;
      dn_n_nxt = 1'b1;
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      pump_up_n_r   <= 1'b1;
      pump_down_n_r <= 1'b1;
      filt_node_r   <= 1'b0;
    end else begin
      pump_up_n_r   <= up_n_nxt;
      pump_down_n_r <= dn_n_nxt;
      filt_node_r   <= !(up_n_nxt && dn_n_nxt);
    end
  end

  // stands in for the external capacitor and comparator: a short quiet stretch
  // is needed before lock is reported, and a single pump pulse withdraws it on the next cycle
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      lock_cnt_r <= 8'h00;
      lock_oe_r  <= 1'b1;
    end else begin
      if (filt_node_r) begin
        lock_cnt_r <= 8'h00;
      end else if (lock_cnt_r != LOCK_FILT_CYC) begin
        lock_cnt_r <= lock_cnt_r + 8'h01;
      end
      lock_oe_r <= (lock_cnt_r != LOCK_FILT_CYC) || filt_node_r;
    end
  end

  assign main_divided_clk  = main_div_r;
  assign ref_divided_clk   = ref_div_r;
  assign pump_up_n         = pump_up_n_r;
  assign pump_down_n       = pump_down_n_r;
  assign lock_filter_node  = filt_node_r;
  assign lock_indicator_o  = 1'b0;
  assign lock_indicator_oe = lock_oe_r;
  assign diag_out          = diag_r;

endmodule
`default_nettype wire

// [ipll_divider_ctrl_checker.sv]
// port checker for the divider control block, bound after the module
`timescale 1ns/10ps
`default_nettype none
module ipll_divider_ctrl_checker (
  input wire logic                 mclk,
  input wire logic                 sys_rst,
  input wire ipll_pkg::ipll_pins_s pins,
  input wire logic                 main_divided_clk,
  input wire logic                 ref_divided_clk,
  input wire logic                 pump_up_n,
  input wire logic                 pump_down_n,
  input wire logic                 lock_filter_node,
  input wire logic                 lock_indicator_o,
  input wire logic                 lock_indicator_oe,
  input wire logic                 diag_out
);
  import ipll_pkg::*;
  logic [7:0] quiet_r;
  // cycles with both pumps idle, saturating
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) quiet_r <= 8'h00;
    else if (!(pump_up_n && pump_down_n)) quiet_r <= 8'h00;
    else if (quiet_r != 8'hFF) quiet_r <= quiet_r + 8'h01;
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  // outputs only mean something once the aux enable has settled high
  sequence s_aux_off;
    pins.aux_ctrl_enable_n [*8];
  endsequence
  a_od_data_low: assert property (lock_indicator_o == 1'b0)
    else $error("lock indicator data not held low");
  a_node_is_nand: assert property (lock_filter_node == !(pump_up_n && pump_down_n))
    else $error("filter node is not the nand of the pumps");
  a_pumps_exclusive: assert property (pump_up_n || pump_down_n)
    else $error("both pumps active together");
  a_lock_held_busy: assert property (!(pump_up_n && pump_down_n) |-> ##2 lock_indicator_oe)
    else $error("lock released while a pump is active");
  a_lock_after_quiet: assert property (quiet_r > LOCK_FILT_CYC + 8'h04 |-> !lock_indicator_oe)
    else $error("lock not released after quiet pumps");
  a_diag_gated_off: assert property (s_aux_off |-> !diag_out)
    else $error("diagnostic output active with aux functions off");
  a_down_main_edge: assert property (s_aux_off ##0 $fell(pump_down_n) |-> ##[0:2] main_divided_clk)
    else $error("down pump not started by a main edge");
  a_up_ref_edge: assert property (s_aux_off ##0 $fell(pump_up_n) |-> ##[0:2] ref_divided_clk)
    else $error("up pump not started by a reference edge");
endmodule
bind ipll_divider_ctrl ipll_divider_ctrl_checker u_chk (
  .mclk(mclk), .sys_rst(sys_rst), .pins(pins), .main_divided_clk(main_divided_clk),
  .ref_divided_clk(ref_divided_clk), .pump_up_n(pump_up_n), .pump_down_n(pump_down_n),
  .lock_filter_node(lock_filter_node), .lock_indicator_o(lock_indicator_o),
  .lock_indicator_oe(lock_indicator_oe), .diag_out(diag_out)
);
`default_nettype wire

// [ipll_ctl_model.sv]
// external controller model: clock sources, mode levels, parallel and serial programming
`timescale 1ns/10ps
`default_nettype none
module ipll_ctl_model (
  input  wire logic           mclk,
  output var ipll_pkg::ipll_pins_s pins
);
  import ipll_pkg::*;
  int unsigned ph = 0;
  initial begin
    pins = '0;
    pins.aux_ctrl_enable_n = 1'b1;
  end
  // rf 200 ns, ref 250 ns: each level lasts at least three mclk
  always @(posedge mclk) begin
    ph <= ph + 1;
    if (ph % 4 == 0) pins.rf_in <= #2 ~pins.rf_in;
    if (ph % 5 == 0) pins.ref_in <= #2 ~pins.ref_in;
  end
  task automatic set_lv(input ipll_mode_e md, input logic bank, input logic en_n, input ipll_prog_s sw);
    @(posedge mclk) #2;
    pins.bus_mode_select = md[1];
    pins.serial_select = md[0];
    pins.par_bank_select = bank;
    pins.ser_bank_select = bank;
    pins.aux_ctrl_enable_n = en_n;
    pins.strap_word = sw;
  endtask
  task automatic strobe(input int w, input logic v);
    case (w)
      0: pins.main_high_bits_strobe = v;
      1: pins.main_low_byte_strobe = v;
      2: pins.swallow_ref_strobe = v;
      3: pins.freq_switch_strobe = v;
      4: pins.aux_reg_strobe = v;
      default: pins.serial_load_strobe = v;
    endcase
  endtask
  // byte held four mclk before the strobe rise and four after its fall, then no longer shown
  task automatic pulse(input int w, input logic [7:0] d);
    @(posedge mclk) #2 pins.par_bus = d;
    #100 strobe(w, 1'b1);
    #100 strobe(w, 1'b0);
    #100 pins.par_bus = ~d;
  endtask
  task automatic par_load(input ipll_prog_s w);
    pulse(0, {4'h0, w[19:16]});
    pulse(1, w[15:8]);
    pulse(2, w[7:0]);
  endtask
  task automatic aux_set(input logic v);
    @(posedge mclk) #2 pins.aux_reg_strobe = v;
  endtask
  // shift clock 200 ns, low between frames; data moves with the falling edge,
  // four mclk after the rise, and is inverted once the frame is over
  task automatic ser_shift(input logic [19:0] w, input int n);
    for (int i = n - 1; i >= 0; i--) begin
      @(posedge mclk) #2;
      pins.serial_in = w[i];
      pins.serial_shift_clock = 1'b0;
      #100 pins.serial_shift_clock = 1'b1;
      #75;
    end
    @(posedge mclk) #2;
    pins.serial_shift_clock = 1'b0;
    pins.serial_in = ~w[0];
  endtask
endmodule
`default_nettype wire

// [test_integer_n_pll_divider_control.sv]
// self-checking bench: divider ratios measured in input edges per output period
`timescale 1ns/10ps
`default_nettype none
module test_integer_n_pll_divider_control;
  import ipll_pkg::*;
  typedef struct {
    string       name;
    int          sel;
    logic [15:0] val;
  } ipll_note_s;
  logic        mclk = 1'b0;
  logic        sys_rst = 1'b1;
  ipll_pins_s  pins;
  logic        main_clk, ref_clk, pu_n, pd_n, node, ld_o, ld_oe, diag;
  ipll_note_s  q[$];
  int unsigned err_count = 0;
  int unsigned compares = 0;
  int unsigned rf_n = 0;
  int unsigned ref_n = 0;
  int unsigned m, a, r;
  always #12.5 mclk = ~mclk;
  always @(posedge pins.rf_in) rf_n++;
  always @(posedge pins.ref_in) ref_n++;
  ipll_ctl_model ctl (.mclk(mclk), .pins(pins));
  ipll_divider_ctrl dut (
    .mclk(mclk), .sys_rst(sys_rst), .pins(pins), .main_divided_clk(main_clk), .ref_divided_clk(ref_clk),
    .pump_up_n(pu_n), .pump_down_n(pd_n), .lock_filter_node(node), .lock_indicator_o(ld_o),
    .lock_indicator_oe(ld_oe), .diag_out(diag)
  );
  function automatic ipll_prog_s mk(input logic [5:0] rv, input logic [8:0] mv, input logic p, input logic [3:0] av);
    return '{rv[5:4], mv[8:7], p, mv[6:0], rv[3:0], av};
  endfunction
  task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch %s expected %0d seen %0d", nm, exp, seen);
    end
  endtask
  task automatic expect_out(input string nm, input int sel, input logic [15:0] v);
    q.push_back('{nm, sel, v});
    wait (q.size() == 0);
    $display("test %s done", nm);
  endtask
  task automatic wrap_up;
    $display("compares %0d err_count %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // period between second and third rise; the first may still carry the old setting
  initial begin
    int unsigned t, c0, cnt, rises;
    logic [15:0] seen;
    logic        cur, prev;
    forever begin
      wait (q.size() != 0);
      c0 = 0;
      seen = 16'h0000;
      rises = 0;
      prev = 1'b1;
      for (t = 0; t < 10000 && rises < 3; t++) begin
        // sampled half a period away from the launching edge
        @(negedge mclk);
        cur = (q[0].sel == 0) ? main_clk : (q[0].sel == 1) ? ref_clk : diag;
        cnt = (q[0].sel == 1) ? ref_n : rf_n;
        if (cur === 1'b1 && prev !== 1'b1) begin
          rises++;
          if (rises == 2) c0 = cnt;
          if (rises == 3) seen = 16'(cnt - c0);
        end
        prev = cur;
      end
      check(q[0].name, seen, q[0].val);
      void'(q.pop_front());
    end
  end
  // tests need about 1.2 ms; twice that means a hang
  initial begin
    #2400000;
    err_count++;
    wrap_up();
  end
  initial begin
    void'($urandom(32'hEB910580));
    m = 1 + $urandom % 7;
    a = $urandom % (m + 2);
    r = $urandom % 4;
    repeat (10) @(posedge mclk);
    #2 sys_rst = 1'b0;
    ctl.set_lv(IPLL_MODE_PAR, 1'b1, 1'b1, '0);
    ctl.par_load(mk(6'h12, 9'h001, 1'b0, 4'h1));
    expect_out("main ratio minimum M", 0, 16'h15);
    expect_out("ref ratio", 1, 16'h13);
    ctl.pulse(3, 8'h00);
    ctl.par_load(mk(6'h00, 9'h180, 1'b1, 4'h7));
    expect_out("bypass ratio", 0, 16'h181);
    expect_out("ref pass through", 1, 16'h1);
    ctl.set_lv(IPLL_MODE_PAR, 1'b0, 1'b1, '0);
    expect_out("secondary ratio", 0, 16'h15);
    ctl.pulse(4, 8'h05);
    expect_out("aux gated off", 0, 16'h15);
    ctl.set_lv(IPLL_MODE_PAR, 1'b0, 1'b0, '0);
    expect_out("outputs disabled", 0, 16'h0);
    ctl.pulse(4, 8'h04);
    expect_out("modulus select on diag", 2, 16'h15);
    ctl.par_load(mk(6'h00, 9'h001, 1'b0, 4'h0));
    ctl.pulse(4, 8'h0A);
    ctl.set_lv(IPLL_MODE_PAR, 1'b1, 1'b0, '0);
    expect_out("prescaler on diag", 2, 16'hA);
    ctl.pulse(4, 8'h10);
    expect_out("power down", 0, 16'h0);
    ctl.pulse(4, 8'h00);
    ctl.set_lv(IPLL_MODE_SER, 1'b0, 1'b0, '0);
    ctl.ser_shift(mk(6'(r), 9'(m), 1'b0, 4'(a)), 20);
    ctl.pulse(5, 8'h00);
    expect_out("serial secondary ratio", 0, 16'(10 * (m + 1) + a));
    expect_out("serial ref ratio", 1, 16'(r + 1));
    ctl.ser_shift(mk(6'h00, 9'h003, 1'b1, 4'h0), 20);
    ctl.par_load(mk(6'h00, 9'h009, 1'b1, 4'h0));
    ctl.set_lv(IPLL_MODE_SER, 1'b1, 1'b0, '0);
    expect_out("serial primary, parallel refused", 0, 16'h4);
    ctl.aux_set(1'b1);
    ctl.ser_shift(20'h00001, 8);
    expect_out("aux shift not yet active", 0, 16'h4);
    ctl.aux_set(1'b0);
    expect_out("serial aux disable", 0, 16'h0);
    ctl.set_lv(IPLL_MODE_STRAP, 1'b1, 1'b1, mk(6'h30, 9'h182, 1'b1, 4'h5));
    expect_out("strap ratio", 0, 16'h3);
    expect_out("strap ref", 1, 16'h1);
    wrap_up();
  end
endmodule
`default_nettype wire
